// ===== hw/cso_clock_source.sv
// Purpose: Clock source selection, oscillator supervision and timer clock gating
// Assumes: Clock pins are sampled in the pclk domain; stop_req comes from pclk logic
// Notes: Derived clocks are registered toggles of sampled source edges
//
// Functional notes
// - Source select 1 gives PLL clock halved; 0 with oscillator up gives oscillator halved.
// - Source select clears only with oscillator up; forced to 1 otherwise.
// - Entering full stop sets the source select back to PLL.
// - Run-in-stop 0 stops oscillator during stop; 1 keeps it running.
// - REAL_TIME_INTERRUPT_TIMER runs in pseudo stop only if enabled and on oscillator; else frozen.
// - Watchdog runs in pseudo stop only if enabled and on oscillator; else frozen.
// - REAL_TIME_INTERRUPT_TIMER clock is RC when select 0, oscillator when 1; change restarts period.
// - REAL_TIME_INTERRUPT_TIMER select sets only with oscillator up; cleared when oscillator down.
// - Watchdog clock is RC or oscillator by select; change restarts period.
// - Watchdog select sets only with oscillator up; cleared when oscillator down.
// - PLL register writes need protect 0 and source select 1; else ignored.
// - Software enables oscillator, waits for up flag, then selects oscillator.
// - Short spikes are filtered from the oscillator clock before use.
// - Unfilterable noise clears up and lock, sets fault and lock-change flags.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "cso_defs.svh"

module cso_clock_source
    import cso_pkg::*;
#(
    parameter int FILT_CYC = `CSO_FILT_CYC,
    parameter int UP_EDGES = `CSO_UP_EDGES,
    parameter int NOISE_LIMIT = `CSO_NOISE_LIMIT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input cso_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_req,
    input wire logic [3:0] clk_pins,
    output logic sys_clk,
    output logic osc_run,
    output logic osc_up,
    output logic [1:0] pll_freq_mod,
    output cso_tmr_t rti_ctl,
    output cso_tmr_t wdog_ctl,
    output logic irq
);

    if (FILT_CYC < 2 || FILT_CYC > 15)
    begin : g_bad_filt
        $error("FILT_CYC out of range");
    end
    if (UP_EDGES < 1 || UP_EDGES > 255)
    begin : g_bad_up
        $error("UP_EDGES out of range");
    end
    if (NOISE_LIMIT < 1 || NOISE_LIMIT > 15)
    begin : g_bad_noise
        $error("NOISE_LIMIT out of range");
    end

    function automatic logic addr_is(input logic [11:0] a, input logic [7:0] idx);
        addr_is = (a == {2'b00, idx, 2'b00});
    endfunction

    cso_state_t st_ff;
    cso_state_t nxt_st;
    logic pll_rise;
    logic rc_rise;
    logic osc_rise;
    logic spike;
    logic fault;
    logic full_stop;
    logic pseudo_stop;
    logic src_edge;
    logic setup;
    logic acc;
    logic hit;
    logic [1:0] clr;
    logic [1:0] ev;

    always_comb
    begin
        nxt_st = st_ff;
        // First stage feeds only the second stage
        nxt_st.s1 = clk_pins;
        nxt_st.s2 = st_ff.s1;
        pll_rise = st_ff.s2[`CSO_PIN_PLL] && !st_ff.pll_d;
        rc_rise = st_ff.s2[`CSO_PIN_RC] && !st_ff.rc_d;
        nxt_st.pll_d = st_ff.s2[`CSO_PIN_PLL];
        nxt_st.rc_d = st_ff.s2[`CSO_PIN_RC];

        // A level must hold FILT_CYC samples to pass; shorter pulses count as spikes
        spike = 1'b0;
        if (st_ff.s2[`CSO_PIN_OSC] != st_ff.osc_f)
        begin
            if (st_ff.filt_cnt == 4'(FILT_CYC - 1))
            begin
                nxt_st.osc_f = st_ff.s2[`CSO_PIN_OSC];
                nxt_st.filt_cnt = 4'h0;
            end
            else
            begin
                nxt_st.filt_cnt = st_ff.filt_cnt + 4'h1;
            end
        end
        else if (st_ff.filt_cnt != 4'h0)
        begin
            spike = 1'b1;
            nxt_st.filt_cnt = 4'h0;
        end
        nxt_st.osc_fd = st_ff.osc_f;
        osc_rise = st_ff.osc_f && !st_ff.osc_fd;

        // Too many spikes within one oscillator period is treated as severe noise
        fault = spike && (st_ff.spike_cnt == 4'(NOISE_LIMIT - 1));
        if (fault || osc_rise)
        begin
            nxt_st.spike_cnt = 4'h0;
        end
        else if (spike)
        begin
            nxt_st.spike_cnt = st_ff.spike_cnt + 4'h1;
        end

        full_stop = stop_req && !st_ff.run_stop;
        pseudo_stop = stop_req && st_ff.run_stop;
        nxt_st.fstop = full_stop;
        nxt_st.osc_run = st_ff.external_osc_enable && !full_stop;

        if (!st_ff.osc_run || fault)
        begin
            nxt_st.up_cnt = 8'h00;
            nxt_st.osc_up = 1'b0;
        end
        else if (osc_rise && !st_ff.osc_up)
        begin
            nxt_st.up_cnt = st_ff.up_cnt + 8'h01;
            if (st_ff.up_cnt == 8'(UP_EDGES - 1))
            begin
                nxt_st.osc_up = 1'b1;
            end
        end

        if (fault)
        begin
            nxt_st.lock_hold = 1'b1;
        end
        else if (!st_ff.s2[`CSO_PIN_LOCK])
        begin
            nxt_st.lock_hold = 1'b0;
        end
        nxt_st.lock = st_ff.s2[`CSO_PIN_LOCK] && !st_ff.lock_hold && !fault;
        ev = {(nxt_st.lock != st_ff.lock) || fault, fault};

        // APB: zero wait states, data captured in the setup cycle
        setup = apb_req.psel && !apb_req.penable;
        acc = apb_req.psel && apb_req.penable && st_ff.pready;
        hit = addr_is(apb_req.paddr, `CSO_IDX_CLKS) || addr_is(apb_req.paddr, `CSO_IDX_PLL)
            || addr_is(apb_req.paddr, `CSO_IDX_OSC) || addr_is(apb_req.paddr, `CSO_IDX_WRITE_PROTECT)
            || addr_is(apb_req.paddr, `CSO_IDX_IFLG) || addr_is(apb_req.paddr, `CSO_IDX_IMSK)
            || addr_is(apb_req.paddr, `CSO_IDX_STAT);
        nxt_st.pready = setup;
        nxt_st.pslverr = setup && !hit;
        nxt_st.prdata = 32'h0000_0000;
        nxt_st.rd_iflg = 2'b00;
        if (setup)
        begin
            if (addr_is(apb_req.paddr, `CSO_IDX_CLKS))
            begin
                nxt_st.prdata[7:0] = {st_ff.sysel, st_ff.run_stop, 2'b00, st_ff.rti_pse,
                    st_ff.wd_pse, st_ff.rti_sel, st_ff.wd_sel};
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_PLL))
            begin
                nxt_st.prdata[`CSO_PLL_FM_LO +: 2] = st_ff.pll_fm;
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_OSC))
            begin
                nxt_st.prdata[`CSO_OSC_EN] = st_ff.external_osc_enable;
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_WRITE_PROTECT))
            begin
                nxt_st.prdata[`CSO_WRITE_PROTECT_BIT] = st_ff.write_protect;
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_IFLG))
            begin
                nxt_st.prdata[1:0] = st_ff.flags;
                nxt_st.rd_iflg = st_ff.flags;
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_IMSK))
            begin
                nxt_st.prdata[1:0] = st_ff.mask;
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_STAT))
            begin
                nxt_st.prdata[1:0] = {st_ff.lock, st_ff.osc_up};
            end
        end

        // Only bits that were reported are cleared, so a new event is never lost
        clr = (acc && !apb_req.pwrite && addr_is(apb_req.paddr, `CSO_IDX_IFLG)) ?
            st_ff.rd_iflg : 2'b00;
        nxt_st.flags = (st_ff.flags & ~clr) | ev;

        if (acc && apb_req.pwrite)
        begin
            if (addr_is(apb_req.paddr, `CSO_IDX_CLKS))
            begin
                nxt_st.run_stop = apb_req.pwdata[`CSO_CLKS_RUNSTOP];
                nxt_st.rti_pse = apb_req.pwdata[`CSO_CLKS_RTIPSE];
                nxt_st.wd_pse = apb_req.pwdata[`CSO_CLKS_WDPSE];
                nxt_st.sysel = apb_req.pwdata[`CSO_CLKS_SYSSEL] || !st_ff.osc_up;
                nxt_st.rti_sel = apb_req.pwdata[`CSO_CLKS_RTISEL] && st_ff.osc_up;
                nxt_st.wd_sel = apb_req.pwdata[`CSO_CLKS_WDSEL] && st_ff.osc_up;
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_PLL) && !st_ff.write_protect && st_ff.sysel)
            begin
                nxt_st.pll_fm = apb_req.pwdata[`CSO_PLL_FM_LO +: 2];
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_OSC))
            begin
                nxt_st.external_osc_enable = apb_req.pwdata[`CSO_OSC_EN];
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_WRITE_PROTECT))
            begin
                nxt_st.write_protect = apb_req.pwdata[`CSO_WRITE_PROTECT_BIT];
            end
            if (addr_is(apb_req.paddr, `CSO_IDX_IMSK))
            begin
                nxt_st.mask = apb_req.pwdata[1:0];
            end
        end

        if (!st_ff.osc_up)
        begin
            nxt_st.sysel = 1'b1;
            nxt_st.rti_sel = 1'b0;
            nxt_st.wd_sel = 1'b0;
        end
        if (full_stop && !st_ff.fstop)
        begin
            nxt_st.sysel = 1'b1;
        end

        // Counters stay outside; withholding ticks freezes them without reset
        nxt_st.rti_tick = (st_ff.rti_sel ? osc_rise : rc_rise)
            && (!stop_req || (pseudo_stop && st_ff.rti_pse && st_ff.rti_sel));
        nxt_st.wd_tick = (st_ff.wd_sel ? osc_rise : rc_rise)
            && (!stop_req || (pseudo_stop && st_ff.wd_pse && st_ff.wd_sel));
        nxt_st.rti_rst = nxt_st.rti_sel != st_ff.rti_sel;
        nxt_st.wd_rst = nxt_st.wd_sel != st_ff.wd_sel;

        // Except from a dead oscillator, switch only at an old-source edge in the low phase: both phases stay whole
        src_edge = st_ff.cur_src ? pll_rise : osc_rise;
        if (!st_ff.cur_src && !st_ff.osc_up)
        begin
            // A dead oscillator gives no edge; a high phase is cut, the low phase kept whole
            if (st_ff.bus_clk)
            begin
                nxt_st.bus_clk = 1'b0;
            end
            else
            begin
                nxt_st.cur_src = 1'b1;
            end
        end
        else if (src_edge)
        begin
            if (st_ff.sysel != st_ff.cur_src && !st_ff.bus_clk)
            begin
                nxt_st.cur_src = st_ff.sysel;
            end
            else if (!stop_req || st_ff.bus_clk)
            begin
                nxt_st.bus_clk = !st_ff.bus_clk;
            end
        end

        nxt_st.irq = |(nxt_st.flags & nxt_st.mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
            st_ff.sysel <= 1'(`CSO_CLKS_RST >> `CSO_CLKS_SYSSEL);
            st_ff.cur_src <= 1'b1;
            st_ff.pll_fm <= `CSO_PLL_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign sys_clk = st_ff.bus_clk;
    assign osc_run = st_ff.osc_run;
    assign osc_up = st_ff.osc_up;
    assign pll_freq_mod = st_ff.pll_fm;
    assign rti_ctl = '{tick: st_ff.rti_tick, restart: st_ff.rti_rst};
    assign wdog_ctl = '{tick: st_ff.wd_tick, restart: st_ff.wd_rst};
    assign irq = st_ff.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_sel_forced_pll: assert property (!st_ff.osc_up |=> st_ff.sysel)
        else $error("source select not forced to PLL");
    a_full_stop_pll: assert property ((stop_req && !st_ff.run_stop) |=> st_ff.sysel)
        else $error("full stop did not select PLL");
    a_osc_stops: assert property ((stop_req && !st_ff.run_stop) |=> !st_ff.osc_run)
        else $error("oscillator kept running in full stop");
    a_rti_frozen: assert property ((stop_req && !(st_ff.run_stop && st_ff.rti_pse
        && st_ff.rti_sel)) |=> !st_ff.rti_tick)
        else $error("real time timer ticked while frozen");
    a_wdog_frozen: assert property ((stop_req && !(st_ff.run_stop && st_ff.wd_pse
        && st_ff.wd_sel)) |=> !st_ff.wd_tick)
        else $error("watchdog ticked while frozen");
    a_rti_restart: assert property ($changed(st_ff.rti_sel) |-> st_ff.rti_rst)
        else $error("real time timer select change without restart");
    a_rti_sel_clear: assert property (!st_ff.osc_up |=> !st_ff.rti_sel)
        else $error("real time timer select not cleared");
    a_wdog_restart: assert property ($changed(st_ff.wd_sel) |-> st_ff.wd_rst)
        else $error("watchdog select change without restart");
    a_wdog_sel_clear: assert property (!st_ff.osc_up |=> !st_ff.wd_sel)
        else $error("watchdog select not cleared");
    a_pll_guard: assert property ((acc && apb_req.pwrite && addr_is(apb_req.paddr,
        `CSO_IDX_PLL) && (st_ff.write_protect || !st_ff.sysel)) |=> $stable(st_ff.pll_fm))
        else $error("guarded PLL register was written");
    a_up_needs_run: assert property ($rose(st_ff.osc_up) |-> $past(st_ff.osc_run))
        else $error("oscillator up without running oscillator");
    a_filter_hold: assert property ($changed(st_ff.osc_f)
        |-> $past(st_ff.filt_cnt) == 4'(FILT_CYC - 1))
        else $error("filtered oscillator changed too early");
    a_noise_fault: assert property (fault |=> (st_ff.flags == 2'b11) && !st_ff.osc_up
        && !st_ff.lock)
        else $error("noise fault not reported");
    a_pll_halved: assert property ((st_ff.cur_src && st_ff.sysel && pll_rise && !stop_req)
        |=> $changed(st_ff.bus_clk))
        else $error("system clock missed a PLL edge");
    a_no_glitch: assert property (($changed(st_ff.bus_clk) && st_ff.cur_src)
        |=> $stable(st_ff.bus_clk))
        else $error("system clock phase shorter than two cycles");
    a_osc_phase: assert property (($changed(st_ff.bus_clk) && !st_ff.cur_src)
        |=> $stable(st_ff.bus_clk))
        else $error("oscillator side clock phase shorter than two cycles");
    a_stop_hold: assert property ((stop_req && !st_ff.bus_clk) |=> !st_ff.bus_clk)
        else $error("system clock pulsed during stop");
    a_rc_rti: assert property ((!st_ff.rti_sel && rc_rise && !stop_req)
        |=> st_ff.rti_tick)
        else $error("real time timer missed an RC edge");
    a_osc_rti: assert property ((st_ff.rti_sel && osc_rise && !stop_req)
        |=> st_ff.rti_tick)
        else $error("real time timer missed an oscillator edge");
    a_rc_wdog: assert property ((!st_ff.wd_sel && rc_rise && !stop_req)
        |=> st_ff.wd_tick)
        else $error("watchdog missed an RC edge");
    a_flag_set_wins: assert property ((ev != 2'b00)
        |=> ((st_ff.flags & $past(ev)) == $past(ev)))
        else $error("event flag lost to a clear");

    c_noise: cover property (fault);
    c_to_osc: cover property ($fell(st_ff.cur_src));
    c_pseudo_rti: cover property (stop_req && st_ff.run_stop && st_ff.rti_tick);
    c_irq: cover property ($rose(st_ff.irq));
    c_forced_pll: cover property (!st_ff.cur_src && !st_ff.osc_up);

endmodule // cso_clock_source

// ===== hw/cso_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the clock source block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Byte address of a register is four times its index
`ifndef CSO_DEFS_SVH
`define CSO_DEFS_SVH

`define CSO_IDX_CLKS 8'h39
`define CSO_IDX_PLL 8'h3A
`define CSO_IDX_OSC 8'h3B
`define CSO_IDX_WRITE_PROTECT 8'h3C
`define CSO_IDX_IFLG 8'h3D
`define CSO_IDX_IMSK 8'h3E
`define CSO_IDX_STAT 8'h3F

`define CSO_CLKS_SYSSEL 7
`define CSO_CLKS_RUNSTOP 6
`define CSO_CLKS_RTIPSE 3
`define CSO_CLKS_WDPSE 2
`define CSO_CLKS_RTISEL 1
`define CSO_CLKS_WDSEL 0
`define CSO_CLKS_RST 8'h80
`define CSO_PLL_FM_LO 4
`define CSO_PLL_RST 2'h0
`define CSO_OSC_EN 0
`define CSO_WRITE_PROTECT_BIT 0
`define CSO_FLG_OSCFLT 0
`define CSO_FLG_LOCKCHG 1

`define CSO_PIN_OSC 0
`define CSO_PIN_PLL 1
`define CSO_PIN_RC 2
`define CSO_PIN_LOCK 3

`define CSO_FILT_CYC 3
`define CSO_UP_EDGES 64
`define CSO_NOISE_LIMIT 4

`endif

// ===== hw/cso_pkg.sv
// Purpose: Types shared by the clock source block
// Assumes: Constants come from cso_defs.svh
// Notes: All module state is one packed struct
package cso_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cso_apb_req_t;

    typedef struct packed {
        logic tick;
        logic restart;
    } cso_tmr_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic pll_d;
        logic rc_d;
        logic osc_f;
        logic osc_fd;
        logic [3:0] filt_cnt;
        logic [3:0] spike_cnt;
        logic [7:0] up_cnt;
        logic osc_up;
        logic lock;
        logic lock_hold;
        logic sysel;
        logic run_stop;
        logic rti_pse;
        logic wd_pse;
        logic rti_sel;
        logic wd_sel;
        logic [1:0] pll_fm;
        logic external_osc_enable;
        logic write_protect;
        logic [1:0] flags;
        logic [1:0] mask;
        logic fstop;
        logic osc_run;
        logic cur_src;
        logic bus_clk;
        logic rti_tick;
        logic rti_rst;
        logic wd_tick;
        logic wd_rst;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] rd_iflg;
        logic irq;
    } cso_state_t;

endpackage

// ===== verif/cso_clock_source_tb_top.sv
// Purpose: Self-checking bench for the clock source and oscillator monitor
// Assumes: APB answers with pready; clock pins driven as sampled levels
// Notes: Short start-up count and noise limit keep the run brief
`timescale 1ns/1ps
`include "cso_defs.svh"

module cso_clock_source_tb_top
    import cso_pkg::*;
();
    logic pclk;
    logic presetn;
    logic stop_req;
    cso_apb_req_t req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sys_clk;
    logic osc_run;
    logic osc_up;
    logic irq;
    logic [1:0] pll_freq_mod;
    cso_tmr_t rti_ctl;
    cso_tmr_t wdog_ctl;
    logic [3:0] pins;
    logic [7:0] cyc;
    int mode;
    int n_errors;
    int check_count;
    int n_rti_rs;
    int n_wd_rs;
    int a;
    int b;
    int d;
    logic [31:0] rd;
    logic err;

    cso_clock_source #(.FILT_CYC(3), .UP_EDGES(2), .NOISE_LIMIT(2)) DUT (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_req(stop_req), .clk_pins(pins),
        .sys_clk(sys_clk), .osc_run(osc_run), .osc_up(osc_up),
        .pll_freq_mod(pll_freq_mod), .rti_ctl(rti_ctl), .wdog_ctl(wdog_ctl), .irq(irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Mode 0 quiet oscillator, 1 running, 2 one-cycle spikes too short to pass
    always @(posedge pclk)
    begin
        cyc <= cyc + 8'h01;
        pins[`CSO_PIN_PLL] <= cyc[1];
        pins[`CSO_PIN_RC] <= cyc[3];
        pins[`CSO_PIN_LOCK] <= 1'b1;
        pins[`CSO_PIN_OSC] <= (mode == 1) ? cyc[2] : ((mode == 2) && (cyc % 6 == 0));
    end

    always @(posedge pclk)
    begin
        if (rti_ctl.restart === 1'b1) n_rti_rs++;
        if (wdog_ctl.restart === 1'b1) n_wd_rs++;
    end

    task complete_run;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Idle cycle after each transfer, so no signal is driven twice in one step
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= {2'b00, idx, 2'b00};
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            $display("unexpected at %0t: no bus answer", $time);
            complete_run();
        end
        @(posedge pclk);
    endtask

    task rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task wait_up;
        int n;
        n = 0;
        while (osc_up !== 1'b1 && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        if (osc_up !== 1'b1)
        begin
            n_errors++;
            $display("unexpected at %0t: oscillator never up", $time);
            complete_run();
        end
    endtask

    // Rising edges of the bus clock and timer ticks over a fixed window
    task measure(output int c, output int r, output int w);
        logic last;
        c = 0;
        r = 0;
        w = 0;
        last = sys_clk;
        repeat (48)
        begin
            @(posedge pclk);
            if (sys_clk === 1'b1 && last === 1'b0) c++;
            if (rti_ctl.tick === 1'b1) r++;
            if (wdog_ctl.tick === 1'b1) w++;
            last = sys_clk;
        end
    endtask

    initial
    begin
        presetn = 1'b0;
        stop_req = 1'b0;
        req = '0;
        mode = 0;
        cyc = 8'h00;
        pins = 4'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`CSO_IDX_CLKS, 32'h0000_0080);
        rchk(`CSO_IDX_PLL, 32'h0000_0000);
        apb(1'b0, 8'h38, 32'h0000_0000);
        chk({31'b0, err}, 32'h0000_0001);
        measure(a, d, d);
        chk({31'b0, (a >= 5 && a <= 7)}, 32'h0000_0001);
        // Oscillator still down: source and timer selects must refuse
        apb(1'b1, `CSO_IDX_CLKS, 32'h0000_0003);
        rchk(`CSO_IDX_CLKS, 32'h0000_0080);
        apb(1'b1, `CSO_IDX_PLL, 32'h0000_0030);
        rchk(`CSO_IDX_PLL, 32'h0000_0030);
        apb(1'b1, `CSO_IDX_WRITE_PROTECT, 32'h0000_0001);
        apb(1'b1, `CSO_IDX_PLL, 32'h0000_0000);
        rchk(`CSO_IDX_PLL, 32'h0000_0030);
        apb(1'b1, `CSO_IDX_WRITE_PROTECT, 32'h0000_0000);
        mode <= 1;
        apb(1'b1, `CSO_IDX_OSC, 32'h0000_0001);
        wait_up();
        chk({31'b0, osc_run}, 32'h0000_0001);
        a = n_rti_rs;
        b = n_wd_rs;
        apb(1'b1, `CSO_IDX_CLKS, 32'h0000_0003);
        rchk(`CSO_IDX_CLKS, 32'h0000_0003);
        chk(n_rti_rs - a, 32'h0000_0001);
        chk(n_wd_rs - b, 32'h0000_0001);
        measure(a, d, d);
        chk({31'b0, (a >= 2 && a <= 4)}, 32'h0000_0001);
        apb(1'b1, `CSO_IDX_PLL, 32'h0000_0010);
        rchk(`CSO_IDX_PLL, 32'h0000_0030);
        chk({30'b0, pll_freq_mod}, 32'h0000_0003);
        // Pseudo stop, first the timer runs and the watchdog freezes, then reversed
        apb(1'b1, `CSO_IDX_CLKS, 32'h0000_004B);
        stop_req <= 1'b1;
        @(posedge pclk);
        measure(d, a, b);
        chk({31'b0, (a >= 5 && a <= 7)}, 32'h0000_0001);
        chk(b, 32'h0000_0000);
        chk({31'b0, osc_run}, 32'h0000_0001);
        stop_req <= 1'b0;
        apb(1'b1, `CSO_IDX_CLKS, 32'h0000_0047);
        stop_req <= 1'b1;
        @(posedge pclk);
        measure(d, a, b);
        chk(a, 32'h0000_0000);
        chk({31'b0, (b >= 5 && b <= 7)}, 32'h0000_0001);
        stop_req <= 1'b0;
        // Severe noise with the interrupt masked, then unmasked and cleared
        apb(1'b1, `CSO_IDX_IMSK, 32'h0000_0000);
        mode <= 2;
        repeat (60) @(posedge pclk);
        mode <= 0;
        repeat (6) @(posedge pclk);
        chk({31'b0, osc_up}, 32'h0000_0000);
        chk({31'b0, irq}, 32'h0000_0000);
        apb(1'b1, `CSO_IDX_IMSK, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        chk({31'b0, irq}, 32'h0000_0001);
        rchk(`CSO_IDX_STAT, 32'h0000_0000);
        rchk(`CSO_IDX_CLKS, 32'h0000_00C4);
        rchk(`CSO_IDX_IFLG, 32'h0000_0003);
        rchk(`CSO_IDX_IFLG, 32'h0000_0000);
        chk({31'b0, irq}, 32'h0000_0000);
        // Full stop stops the oscillator and hands the system clock to the PLL
        mode <= 1;
        wait_up();
        apb(1'b1, `CSO_IDX_CLKS, 32'h0000_0000);
        rchk(`CSO_IDX_CLKS, 32'h0000_0000);
        stop_req <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({31'b0, osc_run}, 32'h0000_0000);
        stop_req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({31'b0, osc_run}, 32'h0000_0001);
        apb(1'b0, `CSO_IDX_CLKS, 32'h0000_0000);
        chk({24'b0, rd[7:0] & 8'h80}, 32'h0000_0080);
        complete_run();
    end
endmodule // cso_clock_source_tb_top
